/* File: rtl/pwm_gating_and_restart_sequencer.sv */
// Purpose: pwm latch, drive gating, shutdown path and divide-by-eight restart
// Assumes: comparator and supply-level inputs are levels, registers over APB
// Notes:   gate_o high turns the power switch on
`timescale 1ns/1ps
`default_nettype none

module pwm_gating_and_restart_sequencer (
    input  wire logic                           clock_i,
    input  wire logic                           rst_n_i,
    // analog comparator and supply-level inputs
    input  wire logic                           osc_pulse_i,
    input  wire logic                           pwm_trip_i,
    input  wire logic                           overtemp_n_i,
    input  wire logic                           feedback_shutdown_input_n_i,
    input  wire logic                           vcc_at_on_level_i,
    input  wire logic                           vcc_at_off_level_i,
    // drive and start-up outputs
    output logic                                gate_o,
    output logic                                startup_en_o,
    output logic                                supply_lockout_o,
    output logic                                fb_clamp_o,
    // APB slave
    input  wire logic                           psel_i,
    input  wire logic                           penable_i,
    input  wire logic                           pwrite_i,
    input  wire logic [pwm_seq_pkg::ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]                    pwdata_i,
    output logic [31:0]                         prdata_o,
    output logic                                pready_o,
    output logic                                pslverr_o
);
    import pwm_seq_pkg::*;

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    if (BLANK_CYC_INT < 1 || BLANK_CYC_INT > 15) begin : g_bad_blank
        $error("blanking count does not fit the blanking counter");
    end
    if (ADDR_W < 4) begin : g_bad_addr
        $error("address width too small for the register map");
    end

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [SYNC_W-1:0] sync1_r;
    logic [SYNC_W-1:0] sync2_r;
    logic              osc_s;
    logic              trip_s;
    logic              ot_n_s;
    logic              sd_n_s;
    logic              vcc_on_s;
    logic              vcc_off_s;
    logic              startup_en_r;
    logic              startup_en_nxt;
    logic              startup_prev_r;
    logic              su_fall_w;
    logic [3:0]        count_r;
    logic [3:0]        count_nxt;
    logic [3:0]        count_inc_w;
    logic              run_w;
    logic              shut_w;
    logic              latch_q_r;
    logic              latch_nxt;
    logic              set_w;
    logic              gate_r;
    logic              gate_nxt;
    logic [3:0]        blank_cnt_r;
    logic [3:0]        blank_cnt_nxt;
    logic              blank_done_w;
    logic              clamp_r;
    logic              force_off_r;
    logic              setup_w;
    logic              access_w;
    logic              sel_ctrl_w;
    logic              sel_status_w;
    logic              hit_w;
    logic [31:0]       rd_data_w;
    logic [31:0]       prdata_r;
    logic              pready_r;
    logic              pslverr_r;
    status_s           status_w;

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    // two flops per input, only the second stage is used
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_r <= SYNC_RST;
            sync2_r <= SYNC_RST;
        end else begin
            sync1_r <= {vcc_at_off_level_i, vcc_at_on_level_i,
                        feedback_shutdown_input_n_i, overtemp_n_i,
                        pwm_trip_i, osc_pulse_i};
            sync2_r <= sync1_r;
        end
    end

    // named views of the synchronised inputs
    assign osc_s     = sync2_r[SY_OSC];
    assign trip_s    = sync2_r[SY_TRIP];
    assign ot_n_s    = sync2_r[SY_OT_N];
    assign sd_n_s    = sync2_r[SY_SD_N];
    assign vcc_on_s  = sync2_r[SY_VCC_ON];
    assign vcc_off_s = sync2_r[SY_VCC_OFF];

    // ----------------------------------------------------------------
    // start-up charging and supply lockout
    // ----------------------------------------------------------------
    // charging stops at turn-on level, restarts at the trip point
    assign startup_en_nxt = (startup_en_r && vcc_on_s)   ? 1'b0 :
                            (!startup_en_r && vcc_off_s) ? 1'b1 :
                            startup_en_r;

    // registered falling edge of the start-up enable
    assign su_fall_w = startup_prev_r & ~startup_en_r;

    // ----------------------------------------------------------------
    // divide-by-eight restart counter
    // ----------------------------------------------------------------
    // counts 1..8, eight is the operating count
    assign count_inc_w = (count_r == CNT_RUN) ? CNT_FIRST : count_r + 4'h1;
    assign count_nxt   = !sd_n_s   ? CNT_PRESET :
                         su_fall_w ? count_inc_w :
                         count_r;

    // operating only with charging off and count at eight
    assign run_w  = ~startup_en_r & (count_r == CNT_RUN);
    // combined shutdown: overtemperature, external shutdown, low supply, software force-off
    assign shut_w = ~ot_n_s | ~sd_n_s | ~run_w | force_off_r;

    // ----------------------------------------------------------------
    // pwm latch, blanking and drive
    // ----------------------------------------------------------------
    // trip only counts after the blanking window of a conducting pulse
    assign blank_done_w = (blank_cnt_r == 4'h0);
    assign set_w        = trip_s & gate_r & blank_done_w;

    // set dominant latch, high output holds the switch off
    assign latch_nxt = set_w ? 1'b1 :
                       osc_s ? 1'b0 :
                       latch_q_r;

    // or of latch, pulse and shutdown inhibits the drive
    assign gate_nxt = ~(latch_nxt | osc_s | shut_w);

    // reload the blanking counter on every turn-on
    assign blank_cnt_nxt = (gate_nxt & ~gate_r) ? BLANK_CYC :
                           blank_done_w ? 4'h0 : blank_cnt_r - 4'h1;

    // sequencer state
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            startup_en_r   <= 1'b1;
            startup_prev_r <= 1'b1;
            count_r        <= CNT_PRESET;
        end else begin
            startup_en_r   <= startup_en_nxt;
            startup_prev_r <= startup_en_r;
            count_r        <= count_nxt;
        end
    end

    // drive path state
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            latch_q_r   <= 1'b1;
            gate_r      <= 1'b0;
            blank_cnt_r <= 4'h0;
            clamp_r     <= 1'b1;
        end else begin
            latch_q_r   <= latch_nxt;
            gate_r      <= gate_nxt;
            blank_cnt_r <= blank_cnt_nxt;
            clamp_r     <= ~run_w;
        end
    end

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    // address decode
    assign setup_w      = psel_i & ~penable_i;
    assign access_w     = psel_i & penable_i;
    assign sel_ctrl_w   = (paddr_i == CTRL_OFF);
    assign sel_status_w = (paddr_i == STATUS_OFF);
    assign hit_w        = sel_ctrl_w | sel_status_w;

    // status word gathers the block's own state
    assign status_w.overtemp     = ~ot_n_s;
    assign status_w.ext_shutdown = ~sd_n_s;
    assign status_w.shutdown     = shut_w;
    assign status_w.running      = run_w;
    assign status_w.clamp        = clamp_r;
    assign status_w.startup_en   = startup_en_r;
    assign status_w.latch_q      = latch_q_r;
    assign status_w.gate         = gate_r;
    assign status_w.count        = count_r;

    // read mux, unmapped reads as zero
    assign rd_data_w = sel_ctrl_w   ? {31'h0, force_off_r} :
                       sel_status_w ? {20'h0, status_w} :
                       32'h0000_0000;

    // read data and error prepared in the setup cycle, zero wait
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
            pready_r  <= 1'b0;
        end else begin
            pready_r <= 1'b1;
            if (setup_w) begin
                prdata_r  <= pwrite_i ? 32'h0000_0000 : rd_data_w;
                pslverr_r <= ~hit_w;
            end
        end
    end

    // control register, written in the access cycle
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            force_off_r <= CTRL_RST[CTRL_FORCE_OFF_BIT];
        end else if (access_w && pwrite_i && sel_ctrl_w) begin
            force_off_r <= pwdata_i[CTRL_FORCE_OFF_BIT];
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign gate_o           = gate_r;
    assign startup_en_o     = startup_en_r;
    assign supply_lockout_o = startup_en_r;
    assign fb_clamp_o       = clamp_r;
    assign prdata_o         = prdata_r;
    assign pready_o         = pready_r;
    assign pslverr_o        = pslverr_r;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    // end of an oscillator pulse with nothing inhibiting
    sequence seq_pulse_end;
        $past(osc_s) && !osc_s && !latch_q_r && !shut_w && !set_w;
    endsequence

    // a fresh turn-on of the drive
    sequence seq_turn_on;
        $rose(gate_r);
    endsequence

    a_set_dominant: assert property ((set_w && osc_s) |=> latch_q_r)
        else $error("latch not set when set and reset coincide");

    a_pulse_drive_low: assert property (osc_s |=> !gate_r)
        else $error("drive high during oscillator pulse");

    a_pulse_end_on: assert property (seq_pulse_end |=> gate_r)
        else $error("drive did not turn on at pulse end");

    a_trip_ends_pulse: assert property (set_w |=> (latch_q_r && !gate_r))
        else $error("pwm trip did not turn the drive off");

    a_shutdown_or: assert property (shut_w |=> !gate_r)
        else $error("drive high while shutdown active");

    a_lockout_low: assert property (startup_en_r |=> !gate_r)
        else $error("drive high during supply lockout");

    a_overtemp_off: assert property (!ot_n_s |-> (status_w.shutdown ##1 !gate_r))
        else $error("drive high during overtemperature");

    a_sd_low_drive: assert property (!sd_n_s |=> !gate_r)
        else $error("drive high during feedback shutdown");

    a_count_held: assert property (!sd_n_s |=> count_r == CNT_PRESET)
        else $error("counter not held at seven in shutdown");

    a_count_to_run: assert property
        ((sd_n_s && su_fall_w && count_r == CNT_PRESET) |=> count_r == CNT_RUN)
        else $error("counter did not advance from seven to eight");

    a_count_edge: assert property
        ((count_r != $past(count_r) && $past(sd_n_s)) |-> $past(su_fall_w))
        else $error("counter moved without start-up enable falling edge");

    a_wrap_restart: assert property
        ((sd_n_s && su_fall_w && count_r == CNT_RUN) |=> count_r == CNT_FIRST)
        else $error("counter did not restart after eight");

    a_turn_on_level: assert property ((startup_en_r && vcc_on_s) |=> !startup_en_r)
        else $error("start-up enable kept at turn-on level");

    a_clamp_standby: assert property (!run_w |=> fb_clamp_o)
        else $error("clamp off while in standby");

    a_blank_window: assert property (seq_turn_on |-> !set_w [*8])
        else $error("current trip seen inside blanking window");

    // blanking counter loaded on the same edge the drive turns on
    a_blank_reload: assert property (seq_turn_on |-> blank_cnt_r == BLANK_CYC)
        else $error("blanking counter not reloaded at turn-on");

    // a trip seen after blanking while conducting
    sequence seq_late_trip;
        trip_s && gate_r && blank_done_w;
    endsequence

    // late trip must end the pulse on the next edge
    a_late_trip_off: assert property (seq_late_trip |=> !gate_r)
        else $error("late current trip did not end the pulse");

    // pulse without a trip leaves the latch cleared
    a_pulse_resets: assert property ((osc_s && !set_w) |=> !latch_q_r)
        else $error("latch not reset by oscillator pulse");

    // software force-off inhibits the drive
    a_force_off_low: assert property (force_off_r |=> !gate_r)
        else $error("drive high while forced off");

    // any count other than eight keeps the drive off
    a_dead_count_off: assert property ((count_r != CNT_RUN) |=> !gate_r)
        else $error("drive high on a dead restart count");

    // restart counter never leaves the one to eight range
    a_count_range: assert property (count_r >= CNT_FIRST && count_r <= CNT_RUN)
        else $error("restart counter out of range");

    // lockout trip point restarts start-up charging
    a_trip_charge_on: assert property ((!startup_en_r && vcc_off_s) |=> startup_en_r)
        else $error("charging not restarted at lockout trip");

    // clamp released once the unit runs
    a_clamp_released: assert property (run_w |=> !fb_clamp_o)
        else $error("clamp still on while running");

    // counter edge is a registered falling edge of charging
    a_su_fall_edge: assert property (su_fall_w |-> ($past(startup_en_r) && !startup_en_r))
        else $error("start-up edge flagged without a falling edge");

endmodule : pwm_gating_and_restart_sequencer

`default_nettype wire

/* File: rtl/pwm_seq_pkg.sv */
// Purpose: shared constants and types for the pwm gating and restart sequencer
// Assumes: 40 MHz system clock, 32-bit APB register access
// Notes:   register offsets are byte addresses
package pwm_seq_pkg;

    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int BLANK_NS      = 200;
    // least time, so round up to whole cycles
    localparam int BLANK_CYC_INT = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] BLANK_CYC = 4'(BLANK_CYC_INT);

    // ----------------------------------------------------------------
    // restart counter values
    // ----------------------------------------------------------------
    localparam logic [3:0] CNT_PRESET = 4'h7;
    localparam logic [3:0] CNT_RUN    = 4'h8;
    localparam logic [3:0] CNT_FIRST  = 4'h1;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int          ADDR_W     = 12;
    localparam logic [11:0] CTRL_OFF   = 12'h000;
    localparam logic [11:0] STATUS_OFF = 12'h004;
    localparam int          CTRL_FORCE_OFF_BIT = 0;
    localparam logic [31:0] CTRL_RST   = 32'h0000_0000;

    // ----------------------------------------------------------------
    // synchroniser bit positions and reset levels
    // ----------------------------------------------------------------
    localparam int SYNC_W       = 6;
    localparam int SY_OSC       = 0;
    localparam int SY_TRIP      = 1;
    localparam int SY_OT_N      = 2;
    localparam int SY_SD_N      = 3;
    localparam int SY_VCC_ON    = 4;
    localparam int SY_VCC_OFF   = 5;
    localparam logic [5:0] SYNC_RST = 6'h0C;

    // status word, read in the low bits of STATUS
    typedef struct packed {
        logic       overtemp;
        logic       ext_shutdown;
        logic       shutdown;
        logic       running;
        logic       clamp;
        logic       startup_en;
        logic       latch_q;
        logic       gate;
        logic [3:0] count;
    } status_s;

endpackage : pwm_seq_pkg

/* File: bench/switch_stage_model.sv */
// Purpose: far side of the drive: oscillator pulse and current comparator
// Assumes: switch current ramps while gate_i is high, falls to zero when off
// Notes:   trip_at_i of zero means the comparator never trips
`timescale 1ns/1ps
`default_nettype none

module switch_stage_model #(
    parameter int PERIOD  = 40,
    parameter int PULSE_W = 6
) (
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    input  wire logic       gate_i,
    input  wire logic [7:0] trip_at_i,
    output logic            osc_pulse_o,
    output logic            trip_o
);
    // ----------------------------------------------------------------
    // oscillator phase and switch on-time
    // ----------------------------------------------------------------
    logic [7:0] phase_r;
    logic [7:0] on_r;

    // free-running phase, on-time counts edges with the switch closed
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_r <= 8'h00;
            on_r    <= 8'h00;
        end else begin
            phase_r <= (phase_r == 8'(PERIOD - 1)) ? 8'h00 : phase_r + 8'h01;
            on_r    <= gate_i ? on_r + 8'h01 : 8'h00;
        end
    end

    // pulse at the start of each period, trip once current has ramped
    assign osc_pulse_o = (phase_r < 8'(PULSE_W));
    assign trip_o      = gate_i && (trip_at_i != 8'h00) && (on_r >= trip_at_i);
endmodule : switch_stage_model
`default_nettype wire

/* File: bench/pwm_gating_and_restart_sequencer_bench.sv */
// Purpose: self-checking bench for the pwm gating and restart sequencer
// Assumes: 40 MHz clock, apb answers when pready_o is high
// Notes:   supply cycles are made by toggling the two supply-level inputs
`timescale 1ns/1ps
`default_nettype none

module pwm_gating_and_restart_sequencer_bench;
    import pwm_seq_pkg::*;

    // ----------------------------------------------------------------
    // signals and instances
    // ----------------------------------------------------------------
    localparam int PER = 40;
    localparam int PW  = 6;
    logic        clock_i, rst_n_i, osc, trip, ot_n, sd_n, von, voff;
    logic        gate, sen, lock, clamp, psel, pen, pwr, pready, perr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0]  trip_at;
    logic        e;
    status_s     s;
    int          bad_count = 0, check_count = 0, rises = 0, hi_run = 0;
    int          last_w = 0, osc_hi = 0, pulse_bad = 0;

    pwm_gating_and_restart_sequencer dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .osc_pulse_i(osc), .pwm_trip_i(trip), .overtemp_n_i(ot_n),
        .feedback_shutdown_input_n_i(sd_n), .vcc_at_on_level_i(von),
        .vcc_at_off_level_i(voff), .gate_o(gate), .startup_en_o(sen),
        .supply_lockout_o(lock), .fb_clamp_o(clamp), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(perr));

    switch_stage_model #(.PERIOD(PER), .PULSE_W(PW)) far (.clock_i(clock_i),
        .rst_n_i(rst_n_i), .gate_i(gate), .trip_at_i(trip_at), .osc_pulse_o(osc),
        .trip_o(trip));

    // clock and watchdog
    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end
    initial begin
        repeat (20000) @(posedge clock_i);
        bad_count++;
        give_verdict();
    end

    // gate pulse width, pulse count and drive during the oscillator pulse
    always @(posedge clock_i) begin
        if (gate === 1'b1) begin
            hi_run <= hi_run + 1;
        end else begin
            if (hi_run != 0) begin
                last_w <= hi_run;
                rises  <= rises + 1;
            end
            hi_run <= 0;
        end
        osc_hi <= (osc === 1'b1) ? osc_hi + 1 : 0;
        if (osc_hi >= 4 && gate !== 1'b0) pulse_bad <= pulse_bad + 1;
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
    endtask : cyc

    task automatic chk_bit(input string n, input logic x, input logic g);
        check_count++;
        if (g !== x) begin
            bad_count++;
            $display("[FAIL] %s expected %b seen %b", n, x, g);
        end
    endtask : chk_bit

    task automatic chk_word(input string n, input logic [31:0] x, input logic [31:0] g);
        check_count++;
        if (g !== x) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, x, g);
        end
    endtask : chk_word

    task automatic chk_range(input string n, input int lo, input int hi, input int g);
        check_count++;
        if (g < lo || g > hi) begin
            bad_count++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", n, lo, hi, g);
        end
    endtask : chk_range

    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel   <= 1'b1;
        pen    <= 1'b0;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clock_i);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) bad_count++;
        q = prdata;
        e = perr;
        psel <= 1'b0;
        pen  <= 1'b0;
        @(posedge clock_i);
    endtask : apb

    task automatic rd_st();
        apb(1'b0, STATUS_OFF, 32'h0);
        s = status_s'(q[11:0]);
    endtask : rd_st

    // does the drive pulse over the next three periods
    task automatic chk_live(input string n, input logic x);
        int r0;
        r0 = rises;
        cyc(3 * PER);
        chk_bit(n, x, logic'(rises != r0));
    endtask : chk_live

    // one supply rise to the turn-on level
    task automatic rise_on();
        voff <= 1'b0;
        von  <= 1'b1;
        cyc(6);
        von <= 1'b0;
        cyc(6);
    endtask : rise_on

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        chk_bit("gate", 1'b0, gate);
        chk_bit("startup", 1'b1, sen);
        chk_bit("lockout", 1'b1, lock);
        chk_bit("clamp", 1'b1, clamp);
        rd_st();
        chk_word("preset count", 32'(CNT_PRESET), 32'(s.count));
        apb(1'b0, 12'h008, 32'h0);
        chk_bit("unmapped error", 1'b1, e);
        chk_word("unmapped data", 32'h0, q);
    endtask : t_reset

    task automatic t_powerup();
        rise_on();
        chk_bit("startup off", 1'b0, sen);
        chk_bit("lockout off", 1'b0, lock);
        chk_bit("clamp off", 1'b0, clamp);
        rd_st();
        chk_word("count run", 32'(CNT_RUN), 32'(s.count));
    endtask : t_powerup

    task automatic t_pwm();
        trip_at <= 8'd20;
        cyc(3 * PER);
        chk_range("trip width", 21, 25, last_w);
        trip_at <= 8'd1;
        cyc(3 * PER);
        chk_range("blank width", BLANK_CYC_INT, BLANK_CYC_INT + 5, last_w);
        trip_at <= 8'd0;
        cyc(3 * PER);
        chk_range("free width", PER - PW - 3, PER - PW + 3, last_w);
        chk_range("pulse drive", 0, 0, pulse_bad);
    endtask : t_pwm

    task automatic t_inhibit();
        ot_n <= 1'b0;
        cyc(6);
        chk_live("overtemp stop", 1'b0);
        ot_n <= 1'b1;
        cyc(6);
        chk_live("overtemp resume", 1'b1);
        apb(1'b1, CTRL_OFF, 32'h1);
        apb(1'b0, CTRL_OFF, 32'h0);
        chk_word("force readback", 32'h1, q);
        chk_live("forced off", 1'b0);
        apb(1'b1, CTRL_OFF, 32'h0);
        chk_live("force released", 1'b1);
        sd_n <= 1'b0;
        cyc(6);
        chk_live("shutdown stop", 1'b0);
        rd_st();
        chk_word("held count", 32'(CNT_PRESET), 32'(s.count));
        sd_n <= 1'b1;
        voff <= 1'b1;
        cyc(6);
        rd_st();
        chk_word("count on rise", 32'(CNT_PRESET), 32'(s.count));
        rise_on();
        rd_st();
        chk_word("count after fall", 32'(CNT_RUN), 32'(s.count));
        chk_live("resumed", 1'b1);
    endtask : t_inhibit

    task automatic t_lockout();
        int r0;
        voff <= 1'b1;
        cyc(6);
        chk_bit("lockout gate", 1'b0, gate);
        chk_bit("charging on", 1'b1, sen);
        chk_bit("clamp standby", 1'b1, clamp);
        r0 = rises;
        for (int i = 1; i <= 8; i++) begin
            rise_on();
            rd_st();
            chk_word("restart count", (i == 8) ? 32'(CNT_RUN) : 32'(i), 32'(s.count));
            if (i < 8) begin
                chk_bit("dead cycle", 1'b0, logic'(rises != r0));
                voff <= 1'b1;
                cyc(6);
            end
        end
        chk_live("restarted", 1'b1);
    endtask : t_lockout

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_n_i = 1'b0;
        ot_n    = 1'b1;
        sd_n    = 1'b1;
        von     = 1'b0;
        voff    = 1'b0;
        trip_at = 8'h00;
        psel    = 1'b0;
        pen     = 1'b0;
        pwr     = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
        repeat (10) @(posedge clock_i);
        rst_n_i <= 1'b1;
        @(posedge clock_i);
        t_reset();
        t_powerup();
        t_pwm();
        t_inhibit();
        t_lockout();
        give_verdict();
    end
endmodule : pwm_gating_and_restart_sequencer_bench
`default_nettype wire
